// ### verilog/hpgc_pkg.sv
// Constants and types shared by the host port and global control block.
`default_nettype none
package hpgc_pkg;
	// Clock rate of the bus and core logic.
	localparam int PCLK_HZ = 25_000_000;
	// Lowest backplane clock rate; the other rates are doublings of it.
	localparam int BP_BASE_HZ = 2_048_000;
	localparam int ACC_W = 24;
	localparam logic [ACC_W-1:0] BP_INC_BASE =
		ACC_W'((64'(BP_BASE_HZ) << ACC_W) / 64'(PCLK_HZ));
	// Reference edges per 8 kHz frame at the T1 and E1 rates.
	localparam logic [8:0] T1_REF_PER_FRAME = 9'd193;
	localparam logic [8:0] E1_REF_PER_FRAME = 9'd256;
	// APB address width; each register takes one aligned word.
	localparam int APB_AW = 12;
	// Register indices (byte address is four times the index).
	localparam logic [7:0] IDX_GCTL1 = 8'h00;
	localparam logic [7:0] IDX_GCLK = 8'h01;
	localparam logic [7:0] IDX_GFRST = 8'h02;
	localparam logic [7:0] IDX_GLRST = 8'h03;
	localparam logic [7:0] IDX_IRQEN = 8'h04;
	localparam logic [7:0] IDX_GREF = 8'h05;
	localparam logic [7:0] IDX_STAT = 8'h06;
	localparam logic [7:0] IDX_PORT_BASE = 8'h10;
	// Per-port register offsets within a 16-entry port block.
	localparam logic [3:0] PR_RX_MM = 4'h0;
	localparam logic [3:0] PR_TX_MM = 4'h1;
	localparam logic [3:0] PR_RX_HDLC = 4'h2;
	localparam logic [3:0] PR_TX_HDLC1 = 4'h3;
	localparam logic [3:0] PR_RX_ES = 4'h4;
	localparam logic [3:0] PR_TX_ES = 4'h5;
	localparam logic [3:0] PR_RX_BOC = 4'h6;
	localparam logic [3:0] PR_LOOP_DN = 4'h7;
	localparam logic [3:0] PR_LOOP_UP = 4'h8;
	localparam logic [3:0] PR_SPARE = 4'h9;
	localparam logic [3:0] PR_LMC = 4'ha;
	localparam logic [3:0] PR_COUNT = 4'hb;
	// Field positions.
	localparam int BWE_BIT = 2;
	localparam int MM_RESET_BIT = 1;
	localparam int RHC_RESET_BIT = 6;
	localparam int TX_HDLC_CONTROL_1_RESET_BIT = 5;
	localparam int ES_RESET_BIT = 2;
	localparam int BOC_RESET_BIT = 7;
	localparam int LMC_TPD_BIT = 0;
	localparam int LMC_RPD_BIT = 1;
	localparam int LMC_TE_BIT = 2;
	localparam int GCLK_RATE_LSB = 0;
	localparam int GCLK_REFOUT_BIT = 2;
	localparam int GCLK_T1_BIT = 3;
	localparam int GCLK_MULT_LSB = 4;
	localparam int GREF_KIND_LSB = 0;
	localparam int GREF_PORT_LSB = 4;
	// Reference source kinds.
	localparam logic [1:0] REF_MCLK = 2'h0;
	localparam logic [1:0] REF_PIN = 2'h1;
	localparam logic [1:0] REF_RCLK = 2'h2;
	localparam logic [7:0] REG_RST = 8'h00;
	typedef enum logic [1:0] {HP_IDLE, HP_READ, HP_WRITE} hpgc_hp_state_t;
endpackage
`default_nettype wire

// ### verilog/hpgc_top.sv
// Host port, register file, clock generation and reset fan-out.
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module hpgc_top #(
	parameter int PORTS = 8
) (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [hpgc_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Parallel host port; in the second style read_strobe_n carries
	// the data strobe and write_strobe_n the read/write direction.
	input wire logic bus_style_select,
	input wire logic chip_select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [12:0] host_addr,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic data_oe,
	// Interrupt pin, open drain
	input wire logic [PORTS-1:0] irq_cond,
	input wire logic irq_out_n_i,
	output logic irq_out_n_o,
	output logic irq_out_n_oe,
	// Hardware reset pin
	input wire logic hw_reset_n,
	// Clock sources and backplane outputs
	input wire logic master_clock_in,
	input wire logic [PORTS-1:0] recovered_clock,
	input wire logic reference_clock_pin_i,
	output logic reference_clock_pin_o,
	output logic reference_clock_pin_oe,
	output logic backplane_clock_out,
	output logic backplane_frame_pulse,
	// Per-port sub-unit resets and power controls
	output logic [PORTS-1:0] framer_bert_reset,
	output logic [PORTS-1:0] line_unit_reset,
	output logic [PORTS-1:0] rx_framer_reset,
	output logic [PORTS-1:0] tx_framer_reset,
	output logic [PORTS-1:0] rx_hdlc_reset,
	output logic [PORTS-1:0] tx_hdlc_reset,
	output logic [PORTS-1:0] rx_elastic_reset,
	output logic [PORTS-1:0] tx_elastic_reset,
	output logic [PORTS-1:0] rx_bitcode_reset,
	output logic [PORTS-1:0] loop_code_restart,
	output logic [PORTS-1:0] spare_code_restart,
	output logic [PORTS-1:0] tx_powerdown,
	output logic [PORTS-1:0] rx_powerdown,
	// Line transmitter pins
	input wire logic [PORTS-1:0] line_tx_pos_data,
	input wire logic [PORTS-1:0] line_tx_neg_data,
	output logic [PORTS-1:0] line_tx_pos_o,
	output logic [PORTS-1:0] line_tx_pos_oe,
	output logic [PORTS-1:0] line_tx_neg_o,
	output logic [PORTS-1:0] line_tx_neg_oe
);
	if (PORTS < 1 || PORTS > 8) begin : g_bad_ports
		$error("PORTS must lie between 1 and 8");
	end

	logic [7:0] gctl1_r, gclk_r, gfrst_r, glrst_r, irqen_r, gref_r;
	logic [7:0] preg_r [0:127];
	hpgc_pkg::hpgc_hp_state_t hp_state_r;
	logic [12:0] hp_adr_r;
	logic [7:0] hp_dat_r;
	logic hp_pend_r;
	logic hp_rd, hp_wr, hp_commit;
	logic apb_ok, apb_wr, apb_acc;
	logic w_en, w_pp;
	logic [7:0] w_idx, w_dat;
	logic [6:0] w_pidx;
	logic [PORTS-1:0] w_ports;
	logic hwr;
	logic mclk_q, mclk_d, refpin_q, ref_d_r, pre_lvl_r;
	logic [PORTS-1:0] rclk_q;
	logic [2:0] presc_cnt_r;
	logic [1:0] mult, ref_kind;
	logic [2:0] ref_port;
	logic ref_lvl, ref_tick, frame_end;
	logic [8:0] fcnt_r;
	logic [hpgc_pkg::ACC_W-1:0] acc_r;

	function automatic logic map_ok(input logic [7:0] idx);
		map_ok = (idx <= hpgc_pkg::IDX_STAT) ||
			(idx[7:4] != 4'h0 && int'(idx[7:4]) <= PORTS &&
			idx[3:0] < hpgc_pkg::PR_COUNT);
	endfunction

	function automatic logic [7:0] rd_val(input logic [7:0] idx);
		rd_val = 8'h00;
		if (map_ok(idx)) begin
			case (idx)
				hpgc_pkg::IDX_GCTL1: rd_val = gctl1_r;
				hpgc_pkg::IDX_GCLK: rd_val = gclk_r;
				hpgc_pkg::IDX_GFRST: rd_val = gfrst_r;
				hpgc_pkg::IDX_GLRST: rd_val = glrst_r;
				hpgc_pkg::IDX_IRQEN: rd_val = irqen_r;
				hpgc_pkg::IDX_GREF: rd_val = gref_r;
				hpgc_pkg::IDX_STAT: begin
					rd_val = {6'h00, backplane_clock_out, irq_out_n_i};
				end
				default: rd_val = preg_r[7'(idx - hpgc_pkg::IDX_PORT_BASE)];
			endcase
		end
	endfunction

	function automatic logic pbit(input int p, input logic [3:0] off,
			input int b);
		logic [7:0] v;
		v = preg_r[{3'(p), off}];
		pbit = v[b];
	endfunction

	// APB answers with one wait state: pready rises in the cycle after
	// the first access cycle.
	assign apb_acc = psel && penable && !pready;
	assign apb_ok = (paddr[hpgc_pkg::APB_AW-1:10] == '0) && map_ok(paddr[9:2]);
	assign apb_wr = psel && penable && pready && pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_acc;
			pslverr <= apb_acc && !apb_ok;
			if (apb_acc) begin
				prdata <= {24'h000000, apb_ok ? rd_val(paddr[9:2]) : 8'h00};
			end
		end
	end

	// Strobe decoding for both styles, gated by chip select.
	assign hp_rd = !chip_select_n && (bus_style_select ?
		(!read_strobe_n && write_strobe_n) :
		(!read_strobe_n && write_strobe_n));
	assign hp_wr = !chip_select_n && (bus_style_select ?
		(!read_strobe_n && !write_strobe_n) :
		!write_strobe_n);
	// A host write waits one cycle if an APB write takes the same edge.
	assign hp_commit = hp_pend_r && !apb_wr;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hp_state_r <= hpgc_pkg::HP_IDLE;
			hp_adr_r <= 13'h0000;
			hp_dat_r <= 8'h00;
			hp_pend_r <= 1'b0;
		end else begin
			if (hp_commit) begin
				hp_pend_r <= 1'b0;
			end
			case (hp_state_r)
				hpgc_pkg::HP_IDLE: begin
					if (hp_wr) begin
						hp_state_r <= hpgc_pkg::HP_WRITE;
						hp_adr_r <= host_addr;
						hp_dat_r <= data_i;
					end else if (hp_rd) begin
						hp_state_r <= hpgc_pkg::HP_READ;
					end
				end
				hpgc_pkg::HP_WRITE: begin
					if (hp_wr) begin
						hp_adr_r <= host_addr;
						hp_dat_r <= data_i;
					end else begin
						// Data is latched on the trailing strobe edge.
						hp_pend_r <= 1'b1;
						hp_state_r <= hpgc_pkg::HP_IDLE;
					end
				end
				hpgc_pkg::HP_READ: begin
					if (!hp_rd) begin
						hp_state_r <= hpgc_pkg::HP_IDLE;
					end
				end
				default: hp_state_r <= hpgc_pkg::HP_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_o <= 8'h00;
			data_oe <= 1'b0;
		end else begin
			data_oe <= hp_rd;
			data_o <= (host_addr[12:8] == 5'h00) ?
				rd_val(host_addr[7:0]) : 8'h00;
		end
	end

	// One write path shared by APB and the host port.
	assign w_en = apb_wr ? apb_ok :
		(hp_commit && hp_adr_r[12:8] == 5'h00 && map_ok(hp_adr_r[7:0]));
	assign w_idx = apb_wr ? paddr[9:2] : hp_adr_r[7:0];
	assign w_dat = apb_wr ? pwdata[7:0] : hp_dat_r;
	assign w_pidx = 7'(w_idx - hpgc_pkg::IDX_PORT_BASE);
	assign w_pp = w_en && (w_idx >= hpgc_pkg::IDX_PORT_BASE);

	always_comb begin
		w_ports = '0;
		if (w_pp) begin
			if (gctl1_r[hpgc_pkg::BWE_BIT]) begin
				w_ports = '1;
			end else begin
				w_ports[w_pidx[6:4]] = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gctl1_r <= hpgc_pkg::REG_RST;
			gclk_r <= hpgc_pkg::REG_RST;
			gfrst_r <= hpgc_pkg::REG_RST;
			glrst_r <= hpgc_pkg::REG_RST;
			irqen_r <= hpgc_pkg::REG_RST;
			gref_r <= hpgc_pkg::REG_RST;
			for (int i = 0; i < 128; i++) begin
				preg_r[i] <= hpgc_pkg::REG_RST;
			end
		end else if (w_en) begin
			case (w_idx)
				hpgc_pkg::IDX_GCTL1: gctl1_r <= w_dat;
				hpgc_pkg::IDX_GCLK: gclk_r <= w_dat;
				hpgc_pkg::IDX_GFRST: gfrst_r <= w_dat;
				hpgc_pkg::IDX_GLRST: glrst_r <= w_dat;
				hpgc_pkg::IDX_IRQEN: irqen_r <= w_dat;
				hpgc_pkg::IDX_GREF: gref_r <= w_dat;
				hpgc_pkg::IDX_STAT: begin
				end
				default: begin
					for (int p = 0; p < PORTS; p++) begin
						if (w_ports[p]) begin
							preg_r[{3'(p), w_idx[3:0]}] <= w_dat;
						end
					end
				end
			endcase
		end
	end

	// Sub-unit resets follow their control bits; register contents
	// survive the hardware pin, so software need not reload them.
	assign hwr = !hw_reset_n;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			framer_bert_reset <= '0;
			line_unit_reset <= '0;
			rx_framer_reset <= '0;
			tx_framer_reset <= '0;
			rx_hdlc_reset <= '0;
			tx_hdlc_reset <= '0;
			rx_elastic_reset <= '0;
			tx_elastic_reset <= '0;
			rx_bitcode_reset <= '0;
			loop_code_restart <= '0;
			spare_code_restart <= '0;
			tx_powerdown <= '0;
			rx_powerdown <= '0;
			line_tx_pos_o <= '0;
			line_tx_pos_oe <= '0;
			line_tx_neg_o <= '0;
			line_tx_neg_oe <= '0;
		end else begin
			framer_bert_reset <= gfrst_r[PORTS-1:0] | {PORTS{hwr}};
			line_unit_reset <= glrst_r[PORTS-1:0] | {PORTS{hwr}};
			line_tx_pos_o <= line_tx_pos_data;
			line_tx_neg_o <= line_tx_neg_data;
			for (int p = 0; p < PORTS; p++) begin
				rx_framer_reset[p] <= pbit(p, hpgc_pkg::PR_RX_MM,
					hpgc_pkg::MM_RESET_BIT);
				tx_framer_reset[p] <= pbit(p, hpgc_pkg::PR_TX_MM,
					hpgc_pkg::MM_RESET_BIT);
				rx_hdlc_reset[p] <= pbit(p, hpgc_pkg::PR_RX_HDLC,
					hpgc_pkg::RHC_RESET_BIT);
				tx_hdlc_reset[p] <= pbit(p, hpgc_pkg::PR_TX_HDLC1,
					hpgc_pkg::TX_HDLC_CONTROL_1_RESET_BIT);
				rx_elastic_reset[p] <= pbit(p, hpgc_pkg::PR_RX_ES,
					hpgc_pkg::ES_RESET_BIT);
				tx_elastic_reset[p] <= pbit(p, hpgc_pkg::PR_TX_ES,
					hpgc_pkg::ES_RESET_BIT);
				rx_bitcode_reset[p] <= pbit(p, hpgc_pkg::PR_RX_BOC,
					hpgc_pkg::BOC_RESET_BIT);
				loop_code_restart[p] <= w_ports[p] &&
					(w_idx[3:0] == hpgc_pkg::PR_LOOP_DN ||
					w_idx[3:0] == hpgc_pkg::PR_LOOP_UP);
				spare_code_restart[p] <= w_ports[p] &&
					w_idx[3:0] == hpgc_pkg::PR_SPARE;
				tx_powerdown[p] <= pbit(p, hpgc_pkg::PR_LMC,
					hpgc_pkg::LMC_TPD_BIT);
				rx_powerdown[p] <= pbit(p, hpgc_pkg::PR_LMC,
					hpgc_pkg::LMC_RPD_BIT);
				// Power-down or a cleared enable both float the pair.
				line_tx_pos_oe[p] <= pbit(p, hpgc_pkg::PR_LMC,
					hpgc_pkg::LMC_TE_BIT) && !pbit(p, hpgc_pkg::PR_LMC,
					hpgc_pkg::LMC_TPD_BIT);
				line_tx_neg_oe[p] <= pbit(p, hpgc_pkg::PR_LMC,
					hpgc_pkg::LMC_TE_BIT) && !pbit(p, hpgc_pkg::PR_LMC,
					hpgc_pkg::LMC_TPD_BIT);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_out_n_o <= 1'b0;
			irq_out_n_oe <= 1'b0;
		end else begin
			irq_out_n_o <= 1'b0;
			irq_out_n_oe <= |(irq_cond & irqen_r[PORTS-1:0]);
		end
	end

	// Clock inputs are sampled once; the master clock must be well
	// below half of pclk for its edges to be seen.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mclk_q <= 1'b0;
			mclk_d <= 1'b0;
			refpin_q <= 1'b0;
			rclk_q <= '0;
			ref_d_r <= 1'b0;
		end else begin
			mclk_q <= master_clock_in;
			mclk_d <= mclk_q;
			refpin_q <= reference_clock_pin_i;
			rclk_q <= recovered_clock;
			ref_d_r <= ref_lvl;
		end
	end

	assign mult = gclk_r[hpgc_pkg::GCLK_MULT_LSB +: 2];
	assign ref_kind = gref_r[hpgc_pkg::GREF_KIND_LSB +: 2];
	assign ref_port = gref_r[hpgc_pkg::GREF_PORT_LSB +: 3];

	// Prescaler divides a 2x, 4x or 8x master clock to the line rate.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_cnt_r <= 3'h0;
			pre_lvl_r <= 1'b0;
		end else if (mclk_q && !mclk_d && mult != 2'h0) begin
			if (presc_cnt_r >= (3'h1 << (mult - 2'h1)) - 3'h1) begin
				presc_cnt_r <= 3'h0;
				pre_lvl_r <= !pre_lvl_r;
			end else begin
				presc_cnt_r <= presc_cnt_r + 3'h1;
			end
		end
	end

	always_comb begin
		ref_lvl = 1'b0;
		case (ref_kind)
			hpgc_pkg::REF_MCLK: ref_lvl = (mult == 2'h0) ? mclk_q : pre_lvl_r;
			hpgc_pkg::REF_PIN: ref_lvl = refpin_q;
			hpgc_pkg::REF_RCLK: begin
				if (int'(ref_port) < PORTS) begin
					ref_lvl = rclk_q[ref_port];
				end
			end
			default: ref_lvl = 1'b0;
		endcase
	end

	assign ref_tick = ref_lvl && !ref_d_r;
	assign frame_end = ref_tick && (fcnt_r == (gclk_r[hpgc_pkg::GCLK_T1_BIT] ?
		hpgc_pkg::T1_REF_PER_FRAME : hpgc_pkg::E1_REF_PER_FRAME) - 9'h1);

	// Frames are counted in reference edges so the frame pulse tracks
	// the chosen reference; the clock phase restarts at each frame.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fcnt_r <= 9'h000;
			acc_r <= '0;
			backplane_clock_out <= 1'b0;
			backplane_frame_pulse <= 1'b0;
			reference_clock_pin_o <= 1'b0;
			reference_clock_pin_oe <= 1'b0;
		end else begin
			if (frame_end) begin
				fcnt_r <= 9'h000;
			end else if (ref_tick) begin
				fcnt_r <= fcnt_r + 9'h001;
			end
			backplane_frame_pulse <= frame_end;
			// The top accumulator bit carries up to a pclk of jitter.
			// Rates above half of pclk alias; 16.384 MHz needs a faster pclk.
			acc_r <= frame_end ? '0 : acc_r + (hpgc_pkg::BP_INC_BASE <<
				gclk_r[hpgc_pkg::GCLK_RATE_LSB +: 2]);
			backplane_clock_out <= acc_r[hpgc_pkg::ACC_W-1];
			reference_clock_pin_o <= ref_lvl;
			reference_clock_pin_oe <= gclk_r[hpgc_pkg::GCLK_REFOUT_BIT] &&
				ref_kind != hpgc_pkg::REF_PIN;
		end
	end
endmodule
`default_nettype wire

// ### verif/hpgc_properties.sv
// Port-level checker for the host port and global control block.
`timescale 1ns/1ps
`default_nettype none
module hpgc_properties #(
	parameter int PORTS = 8
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	// Host port and interrupt
	input wire logic chip_select_n,
	input wire logic data_oe,
	input wire logic [PORTS-1:0] irq_cond,
	input wire logic irq_out_n_o,
	input wire logic irq_out_n_oe,
	// Resets, clocks and line controls
	input wire logic hw_reset_n,
	input wire logic backplane_frame_pulse,
	input wire logic [PORTS-1:0] framer_bert_reset,
	input wire logic [PORTS-1:0] line_unit_reset,
	input wire logic [PORTS-1:0] loop_code_restart,
	input wire logic [PORTS-1:0] tx_powerdown,
	input wire logic [PORTS-1:0] line_tx_pos_oe,
	input wire logic [PORTS-1:0] line_tx_neg_oe
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_ready_wait: assert property (
		psel && $rose(penable) |=> pready)
		else $error("pready late");
	a_ready_pulse: assert property (
		pready |=> !pready)
		else $error("pready held");
	a_refuse_zero: assert property (
		pslverr |-> pready && prdata == 32'h0)
		else $error("refusal data");
	a_cs_ignored: assert property (
		chip_select_n [*3] |-> !data_oe)
		else $error("drive without select");
	a_irq_drain: assert property (
		irq_out_n_oe |-> !irq_out_n_o)
		else $error("irq drives high");
	a_irq_quiet: assert property (
		!(|irq_cond) [*2] |-> !irq_out_n_oe)
		else $error("irq without cause");
	a_hw_reset: assert property (
		!hw_reset_n [*3] |-> (&framer_bert_reset) && (&line_unit_reset))
		else $error("hw reset not spread");
	a_pd_float: assert property (
		!(|(tx_powerdown & $past(tx_powerdown) &
		(line_tx_pos_oe | line_tx_neg_oe))))
		else $error("powered-down line driven");
	a_frame_pulse: assert property (
		backplane_frame_pulse |=> !backplane_frame_pulse)
		else $error("frame pulse too long");
	a_restart_pulse: assert property (
		|loop_code_restart |=> !(|loop_code_restart))
		else $error("restart too long");
	c_refused: cover property (pslverr);
	c_irq: cover property (irq_out_n_oe);
	c_frame: cover property (backplane_frame_pulse);
endmodule
bind hpgc_top hpgc_properties #(.PORTS(PORTS)) u_props (.pclk, .presetn,
	.psel, .penable, .pready, .pslverr, .prdata, .chip_select_n, .data_oe,
	.irq_cond, .irq_out_n_o, .irq_out_n_oe, .hw_reset_n,
	.backplane_frame_pulse, .framer_bert_reset, .line_unit_reset,
	.loop_code_restart, .tx_powerdown, .line_tx_pos_oe, .line_tx_neg_oe);
`default_nettype wire

// ### verif/hpgc_host_model.sv
// Behavioural host processor on the eight-bit parallel port.
`timescale 1ns/1ps
`default_nettype none
module hpgc_host_model (
	// Clock and bus style
	input wire logic pclk,
	input wire logic bus_style_select,
	// Parallel bus towards the block
	output logic chip_select_n,
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic [12:0] host_addr,
	output logic [7:0] data_i,
	// Read data from the block
	input wire logic [7:0] data_o,
	input wire logic data_oe
);
	initial begin
		chip_select_n = 1'b1;
		read_strobe_n = 1'b1;
		write_strobe_n = 1'b1;
		host_addr = 13'h1fff;
		data_i = 8'hff;
	end
	// A released bus shows inverted values so stale data cannot match.
	task automatic cycle(input logic rd, input logic [7:0] idx,
		input logic [7:0] wd, input logic sel, output logic [7:0] rdat,
		output logic ok);
		@(posedge pclk);
		chip_select_n <= ~sel;
		host_addr <= {5'h00, idx};
		data_i <= wd;
		read_strobe_n <= bus_style_select ? 1'b0 : ~rd;
		write_strobe_n <= rd;
		repeat (3) @(posedge pclk);
		ok = rd ? (data_oe === 1'b1) : 1'b1;
		rdat = data_o;
		chip_select_n <= 1'b1;
		read_strobe_n <= 1'b1;
		write_strobe_n <= 1'b1;
		host_addr <= {5'h1f, ~idx};
		data_i <= ~wd;
		repeat (3) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

// ### verif/hpgc_top_tb.sv
// Self-checking bench for the host port and global control block.
`timescale 1ns/1ps
`default_nettype none
module hpgc_top_tb;
	localparam int PORTS = 8;
	// Row: register index, write data, output select, port, level.
	typedef struct packed {
		logic [7:0] idx;
		logic [7:0] wd;
		logic [3:0] s;
		logic [2:0] p;
		logic v;
	} hpgc_row_t;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, bus_style_select = 1'b0, hw_reset_n = 1'b1;
	logic [1:0] div = 2'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [PORTS-1:0] irq_cond = 8'h00, txd = 8'h00;
	logic pready, pslverr, data_oe, irq_out_n_o, irq_out_n_oe;
	logic reference_clock_pin_o, reference_clock_pin_oe;
	logic backplane_clock_out, backplane_frame_pulse;
	logic chip_select_n, read_strobe_n, write_strobe_n;
	logic [12:0] host_addr;
	logic [7:0] data_i, data_o;
	logic [PORTS-1:0] framer_bert_reset, line_unit_reset, rx_framer_reset;
	logic [PORTS-1:0] tx_framer_reset, rx_hdlc_reset, tx_hdlc_reset;
	logic [PORTS-1:0] rx_elastic_reset, tx_elastic_reset, rx_bitcode_reset;
	logic [PORTS-1:0] loop_code_restart, spare_code_restart, tx_powerdown;
	logic [PORTS-1:0] rx_powerdown, line_tx_pos_o, line_tx_pos_oe;
	logic [PORTS-1:0] line_tx_neg_o, line_tx_neg_oe;
	int err_count = 0, checked = 0;
	hpgc_row_t rows [18] = '{24'h0205c5, 24'h0200c4, 24'h0380df,
		24'h0300de, 24'h300205, 24'h310215, 24'h324025, 24'h332035,
		24'h340445, 24'h350455, 24'h368065, 24'h375a75, 24'h38a575,
		24'h393c85, 24'h3a04b5, 24'h3a05b4, 24'h3a0595, 24'h3a06a5};
	logic [11:0] bad [4] = '{12'h01c, 12'h0ec, 12'h240, 12'hc00};
	// The interrupt line has a pull-up resistor.
	wire logic irq_out_n_i = irq_out_n_oe ? irq_out_n_o : 1'b1;
	wire logic master_clock_in = div[1];
	wire logic reference_clock_pin_i = reference_clock_pin_oe ?
		reference_clock_pin_o : div[1];
	// Only port 3 recovers a clock, so a wrong port choice shows.
	wire logic [PORTS-1:0] recovered_clock = {4'h0, div[1], 3'h0};
	wire logic [PORTS-1:0] line_tx_pos_data = txd;
	wire logic [PORTS-1:0] line_tx_neg_data = ~txd;
	wire logic [16*PORTS-1:0] obs = {{PORTS{reference_clock_pin_oe}},
		{PORTS{irq_out_n_oe}}, line_unit_reset, framer_bert_reset,
		line_tx_pos_oe, rx_powerdown, tx_powerdown, spare_code_restart,
		loop_code_restart, rx_bitcode_reset, tx_elastic_reset,
		rx_elastic_reset, tx_hdlc_reset, rx_hdlc_reset, tx_framer_reset,
		rx_framer_reset};
	hpgc_top #(.PORTS(PORTS)) uut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.bus_style_select, .chip_select_n, .read_strobe_n, .write_strobe_n,
		.host_addr, .data_i, .data_o, .data_oe, .irq_cond, .irq_out_n_i,
		.irq_out_n_o, .irq_out_n_oe, .hw_reset_n, .master_clock_in,
		.recovered_clock, .reference_clock_pin_i, .reference_clock_pin_o,
		.reference_clock_pin_oe, .backplane_clock_out,
		.backplane_frame_pulse, .framer_bert_reset, .line_unit_reset,
		.rx_framer_reset, .tx_framer_reset, .rx_hdlc_reset, .tx_hdlc_reset,
		.rx_elastic_reset, .tx_elastic_reset, .rx_bitcode_reset,
		.loop_code_restart, .spare_code_restart, .tx_powerdown,
		.rx_powerdown, .line_tx_pos_data, .line_tx_neg_data, .line_tx_pos_o,
		.line_tx_pos_oe, .line_tx_neg_o, .line_tx_neg_oe);
	hpgc_host_model host (.pclk, .bus_style_select, .chip_select_n,
		.read_strobe_n, .write_strobe_n, .host_addr, .data_i, .data_o,
		.data_oe);
	initial forever #20 pclk = ~pclk;
	always @(posedge pclk) begin
		div <= div + 2'h1;
		txd <= txd + 8'h01;
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
		checked++;
		if (got !== ex) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [7:0] wd, output logic [31:0] rd, output logic er);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			chk("pready", 32'h1, 32'h0);
			complete_run();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, {2'h0, i, 2'h0}, d, r, e);
	endtask
	task automatic rdchk(input string nm, input logic [7:0] i,
		input logic [7:0] ex);
		logic [31:0] r;
		logic e;
		apb(1'b0, {2'h0, i, 2'h0}, 8'h00, r, e);
		chk(nm, {24'h0, ex}, r);
		chk({nm, " error"}, 32'h0, {31'h0, e});
	endtask
	// Waits a few cycles for a selected output bit to reach a level.
	task automatic expect_bit(input string nm, input logic [3:0] s,
		input logic [2:0] p, input logic v);
		int n;
		for (n = 0; n < 6 && obs[s*PORTS+p] !== v; n++)
			@(posedge pclk);
		chk(nm, {31'h0, v}, {31'h0, obs[s*PORTS+p]});
	endtask
	// The last of three frame intervals is counted, so a config change
	// in mid-frame cannot shorten it.
	task automatic measure(input int gap, input int bp);
		int k, c, b;
		logic q;
		q = backplane_clock_out;
		for (k = 0; k < 3; k++) begin
			c = 0;
			b = 0;
			do begin
				@(posedge pclk);
				c++;
				b += int'(backplane_clock_out === 1'b1 && q !== 1'b1);
				q = backplane_clock_out;
			end while (backplane_frame_pulse !== 1'b1 && c < 4000);
		end
		chk("frame gap", gap, c);
		if (c >= 4000)
			complete_run();
		if (b < bp - 3 || b > bp + 3)
			chk("backplane edges", bp, b);
	endtask
	initial begin
		logic [31:0] r;
		logic [7:0] hd;
		logic e, ok;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++)
			rdchk("reset value", 8'(i), 8'h00);
		chk("line oe", 32'h0, {24'h0, line_tx_pos_oe});
		chk("line neg oe", 32'h0, {24'h0, line_tx_neg_oe});
		// Line data is a copy of the inputs one edge late.
		chk("line data", {16'h0, ~(txd - 8'h01), txd - 8'h01},
			{16'h0, line_tx_neg_o, line_tx_pos_o});
		$display("TEST reset done");
		foreach (rows[k]) begin
			wr(rows[k].idx, rows[k].wd);
			expect_bit("row out", rows[k].s, rows[k].p, rows[k].v);
			rdchk("row readback", rows[k].idx, rows[k].wd);
		end
		$display("TEST rows done");
		foreach (bad[k]) begin
			apb(1'b0, bad[k], 8'h00, r, e);
			chk("unmapped error", 32'h1, {31'h0, e});
			chk("unmapped data", 32'h0, r);
		end
		$display("TEST unmapped done");
		wr(8'h00, 8'h04);
		wr(8'h1a, 8'h01);
		expect_bit("bulk last", 4'h9, 3'h7, 1'b1);
		chk("bulk all", 32'hff, {24'h0, tx_powerdown});
		wr(8'h00, 8'h00);
		wr(8'h4a, 8'h00);
		expect_bit("single", 4'h9, 3'h3, 1'b0);
		chk("single only", 32'hf7, {24'h0, tx_powerdown});
		rdchk("bulk copy", 8'h3a, 8'h01);
		$display("TEST bulk done");
		host.cycle(1'b0, 8'h04, 8'h01, 1'b1, hd, ok);
		rdchk("host write s0", 8'h04, 8'h01);
		bus_style_select <= 1'b1;
		host.cycle(1'b0, 8'h04, 8'h03, 1'b1, hd, ok);
		rdchk("host write s1", 8'h04, 8'h03);
		host.cycle(1'b1, 8'h04, 8'h00, 1'b1, hd, ok);
		chk("host read s1", {23'h0, ok, 8'h03}, {23'h0, 1'b1, hd});
		host.cycle(1'b0, 8'h04, 8'hff, 1'b0, hd, ok);
		host.cycle(1'b1, 8'h04, 8'h00, 1'b0, hd, ok);
		chk("no select read", 32'h0, {31'h0, ok});
		rdchk("no select write", 8'h04, 8'h03);
		bus_style_select <= 1'b0;
		host.cycle(1'b1, 8'h04, 8'h00, 1'b1, hd, ok);
		chk("host read s0", {23'h0, ok, 8'h03}, {23'h0, 1'b1, hd});
		$display("TEST host port done");
		irq_cond <= 8'h04;
		repeat (3) @(posedge pclk);
		expect_bit("irq masked", 4'he, 3'h0, 1'b0);
		irq_cond <= 8'h02;
		expect_bit("irq raised", 4'he, 3'h0, 1'b1);
		wr(8'h04, 8'h00);
		expect_bit("irq mask", 4'he, 3'h0, 1'b0);
		irq_cond <= 8'h00;
		$display("TEST irq done");
		hw_reset_n <= 1'b0;
		expect_bit("hw reset framer", 4'hc, 3'h5, 1'b1);
		expect_bit("hw reset line", 4'hd, 3'h1, 1'b1);
		repeat (4) @(posedge pclk);
		hw_reset_n <= 1'b1;
		expect_bit("hw reset off", 4'hc, 3'h5, 1'b0);
		rdchk("kept register", 8'h3a, 8'h01);
		$display("TEST hw reset done");
		wr(8'h05, 8'h01);
		wr(8'h01, 8'h00);
		measure(1024, 84);
		// The fastest rate aliases at this pclk, so 8.192 MHz is measured.
		wr(8'h01, 8'h0a);
		measure(772, 253);
		wr(8'h05, 8'h32);
		measure(772, 253);
		wr(8'h05, 8'h00);
		wr(8'h01, 8'h10);
		measure(2048, 168);
		wr(8'h01, 8'h04);
		expect_bit("ref pin out", 4'hf, 3'h0, 1'b1);
		chk("ref pin level", {31'h0, ~div[1]}, {31'h0, reference_clock_pin_o});
		$display("TEST clocks done");
		complete_run();
	end
endmodule
`default_nettype wire
